// ===== rtl/tuning_pkg.sv
// shared constants and types for the tuning, store and mains control block
package tuning_pkg;

    // ****************************************************************
    // clock and times
    // ****************************************************************
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned POR_TIME_MS = 130;
    localparam int unsigned MAINS_HOLD_MS = 300;
    localparam int unsigned READ_DELAY_MS = 1000;
    localparam int unsigned AFT_HOLD_MS = 1000;
    localparam int unsigned ACCEL_STAGE_MS = 1000;
    localparam int unsigned POR_CYC = POR_TIME_MS * CYC_PER_MS;
    localparam int unsigned MAINS_HOLD_CYC = MAINS_HOLD_MS * CYC_PER_MS;
    localparam int unsigned READ_DELAY_CYC = READ_DELAY_MS * CYC_PER_MS;
    localparam int unsigned AFT_HOLD_CYC = AFT_HOLD_MS * CYC_PER_MS;
    localparam int unsigned ACCEL_STAGE_CYC = ACCEL_STAGE_MS * CYC_PER_MS;

    // ****************************************************************
    // manual tuning rates
    // ****************************************************************
    localparam int unsigned VHF_STEP_HZ = 64;
    localparam int unsigned UHF_STEP_HZ = 16;
    localparam int unsigned VHF_PERIOD_CYC = CLK_HZ / VHF_STEP_HZ;
    localparam int unsigned UHF_PERIOD_CYC = CLK_HZ / UHF_STEP_HZ;
    localparam logic [1:0] ACCEL_LAST_STAGE = 2'h3;

    // ****************************************************************
    // field widths and values
    // ****************************************************************
    localparam int unsigned TUNE_W = 13;
    localparam int unsigned POS_W = 4;
    localparam int unsigned NUM_POS = 16;
    localparam int unsigned NUM_BANDS = 4;
    localparam logic [12:0] TUNE_MIN = 13'h0000;
    localparam logic [12:0] TUNE_MAX = 13'h1fff;
    localparam logic [3:0] POS_FIRST = 4'h0;
    localparam logic [1:0] BAND_VHF1 = 2'h0;
    localparam logic [1:0] BAND_CATV = 2'h1;
    localparam logic [1:0] BAND_VHF3 = 2'h2;
    localparam logic [1:0] BAND_UHF = 2'h3;

    typedef enum logic [1:0] {M_POR, M_OFF, M_DELAY, M_ON} mains_e;

endpackage : tuning_pkg

// ===== rtl/pin_sync.sv
// two-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule : pin_sync
`default_nettype wire

// ===== rtl/accel_stepper.sv
// step pulse generator with rate doubling while a tuning key is held
`timescale 1ns/10ps
`default_nettype none
module accel_stepper #(
    parameter int unsigned STAGE_CYC = 250_000_000,
    parameter int unsigned FAST_PERIOD = 3_906_250,
    parameter int unsigned SLOW_PERIOD = 15_625_000
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic hold_in,
    input wire logic slow_in,
    output logic step_out
);
    logic hold_d_r;
    logic [1:0] stage_r;
    logic [1:0] stage_nxt;
    logic [31:0] sec_cnt_r;
    logic [31:0] sec_cnt_nxt;
    logic [31:0] per_cnt_r;
    logic [31:0] per_cnt_nxt;
    logic step_r;
    logic step_nxt;
    logic [31:0] period;

    always_comb
    begin
        period = (slow_in ? 32'(SLOW_PERIOD) : 32'(FAST_PERIOD)) >> stage_r;
        stage_nxt = stage_r;
        sec_cnt_nxt = sec_cnt_r;
        per_cnt_nxt = per_cnt_r;
        step_nxt = 1'b0;
        if (!hold_in)
        begin
            stage_nxt = 2'h0;
            sec_cnt_nxt = 32'h0;
            per_cnt_nxt = 32'h0;
        end
        else if (!hold_d_r)
        begin
            // fresh press: timer restarts, first step at once
            stage_nxt = 2'h0; // R20
            sec_cnt_nxt = 32'h0;
            per_cnt_nxt = 32'h0;
            step_nxt = 1'b1;
        end
        else
        begin
            if (per_cnt_r + 32'h1 >= period) // R1
            begin
                per_cnt_nxt = 32'h0;
                step_nxt = 1'b1;
            end
            else
            begin
                per_cnt_nxt = per_cnt_r + 32'h1;
            end
            // rate stays at the last stage once reached
            if (stage_r != tuning_pkg::ACCEL_LAST_STAGE) // R20
            begin
                if (sec_cnt_r + 32'h1 >= STAGE_CYC)
                begin
                    sec_cnt_nxt = 32'h0;
                    stage_nxt = stage_r + 2'h1; // R1
                end
                else
                begin
                    sec_cnt_nxt = sec_cnt_r + 32'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            hold_d_r <= 1'b0;
            stage_r <= 2'h0;
            sec_cnt_r <= 32'h0;
            per_cnt_r <= 32'h0;
            step_r <= 1'b0;
        end
        else
        begin
            hold_d_r <= hold_in;
            stage_r <= stage_nxt;
            sec_cnt_r <= sec_cnt_nxt;
            per_cnt_r <= per_cnt_nxt;
            step_r <= step_nxt;
        end
    end

    assign step_out = step_r;
endmodule : accel_stepper
`default_nettype wire

// ===== rtl/tuning_store_mains_control.sv
// tuning counter, store interlock, memory position, band and mains sequencing
//
// Notes on behaviour
// R1: held manual tuning steps 64/s VHF, 16/s UHF/CATV, doubling each second to x8.
// R2: after one store cycle further stores are inhibited.
// R3: program change or tuning re-enables storing; AFT corrections do not.
// R4: plain store writes tuning, fine and band into the selected position.
// R5: accepted addressed store blanks all position indicator outputs.
// R6: position selection then starts the write and restores the display.
// R7: option low switches mains on at power-up and reads position 1; high gives standby.
// R8: mains-on command must persist over 0.3 s; shorter ones are ignored.
// R9: every mains-on performs a memory read delayed by 1 s.
// R10: power-up switch-on waits 0.13 s reset plus 1 s before the read.
// R11: a repeated mains command switches the set off again.
// R12: last position is kept; next mains-on returns to it and reads it.
// R13: position outputs only indicate, never sampled.
// R14: direct selection comes only from remote; local keys only step.
// R15: station option grounded makes stepping skip positions 9 to 16.
// R16: up to 4 band outputs; one held at ground is disabled and skipped.
// R17: band stepping cycles VHF I, CATV, VHF III, UHF, one per command.
// R18: remote manual tuning steps once per two received commands.
// R19: linear AFT defeat low during manual tuning and 1 s after release.
// R20: acceleration restarts at each press and saturates after three seconds.
// R21: tuning counter saturates at its ends, no wrap and no band change.
`timescale 1ns/10ps
`default_nettype none
module tuning_store_mains_control #(
    parameter int unsigned POR_CYC = tuning_pkg::POR_CYC,
    parameter int unsigned MAINS_HOLD_CYC = tuning_pkg::MAINS_HOLD_CYC,
    parameter int unsigned READ_DELAY_CYC = tuning_pkg::READ_DELAY_CYC,
    parameter int unsigned AFT_HOLD_CYC = tuning_pkg::AFT_HOLD_CYC,
    parameter int unsigned ACCEL_STAGE_CYC = tuning_pkg::ACCEL_STAGE_CYC,
    parameter int unsigned VHF_PERIOD_CYC = tuning_pkg::VHF_PERIOD_CYC,
    parameter int unsigned UHF_PERIOD_CYC = tuning_pkg::UHF_PERIOD_CYC
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic poweron_opt_in,
    input wire logic station16_opt_in,
    input wire logic [3:0] band_pin_in,
    input wire logic tune_up_in,
    input wire logic tune_down_in,
    input wire logic rc_tune_up_in,
    input wire logic rc_tune_down_in,
    input wire logic afc_up_in,
    input wire logic afc_down_in,
    input wire logic mem_up_in,
    input wire logic mem_down_in,
    input wire logic rc_sel_valid_in,
    input wire logic [3:0] rc_sel_in,
    input wire logic store_cmd_in,
    input wire logic addr_store_cmd_in,
    input wire logic band_step_in,
    input wire logic mains_cmd_in,
    input wire logic [3:0] fine_in,
    input wire logic rd_valid_in,
    input wire logic [12:0] rd_tune_in,
    input wire logic [1:0] rd_band_in,
    output logic mains_on_out,
    output logic [15:0] mem_pos_out,
    output logic [3:0] band_out,
    output logic [3:0] band_oe_n_out,
    output logic [12:0] tune_out,
    output logic [3:0] fine_out,
    output logic [1:0] band_code_out,
    output logic [3:0] mem_addr_out,
    output logic mem_write_out,
    output logic mem_read_out,
    output logic lin_aft_defeat_n_out
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [12:0] sat_step(input logic [12:0] val, input logic up);
        logic [12:0] res;
        res = val;
        if (up && val != tuning_pkg::TUNE_MAX)
        begin
            res = val + 13'h1;
        end
        else if (!up && val != tuning_pkg::TUNE_MIN)
        begin
            res = val - 13'h1;
        end
        return res;
    endfunction : sat_step

    function automatic logic [3:0] next_pos(input logic [3:0] pos, input logic up, input logic short);
        logic [3:0] res;
        res = up ? pos + 4'h1 : pos - 4'h1;
        if (short)
        begin
            res = {1'b0, res[2:0]};
        end
        return res;
    endfunction : next_pos

    function automatic logic [1:0] next_band(input logic [1:0] cur, input logic [3:0] en);
        logic [1:0] res;
        logic [1:0] cand;
        res = cur;
        for (int i = 3; i >= 1; i--)
        begin
            cand = cur + 2'(i);
            if (en[cand])
            begin
                res = cand;
            end
        end
        return res;
    endfunction : next_band

    // ****************************************************************
    // pin synchronisers and step generator
    // ****************************************************************
    logic poweron_opt_s;
    logic station16_opt_s;
    logic [3:0] band_pin_s;
    logic accel_step;
    logic key_hold;
    logic [1:0] band_r;

    pin_sync #(.W(2), .RST_VAL(2'h3)) u_opt_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .async_in({poweron_opt_in, station16_opt_in}),
        .sync_out({poweron_opt_s, station16_opt_s})
    );

    pin_sync #(.W(4), .RST_VAL(4'hf)) u_band_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .async_in(band_pin_in),
        .sync_out(band_pin_s)
    );

    accel_stepper #(
        .STAGE_CYC(ACCEL_STAGE_CYC),
        .FAST_PERIOD(VHF_PERIOD_CYC),
        .SLOW_PERIOD(UHF_PERIOD_CYC)
    ) u_stepper (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .hold_in(key_hold),
        .slow_in(band_r[0]), // R1
        .step_out(accel_step)
    );

    // ****************************************************************
    // state
    // ****************************************************************
    tuning_pkg::mains_e mains_r, mains_nxt;
    logic [31:0] timer_r, timer_nxt;
    logic [31:0] hold_cnt_r, hold_cnt_nxt;
    logic [31:0] aft_cnt_r, aft_cnt_nxt;
    logic cmd_d_r;
    logic on_r, on_nxt;
    logic [3:0] pos_r, pos_nxt;
    logic store_en_r, store_en_nxt;
    logic addr_wait_r, addr_wait_nxt;
    logic [12:0] tune_r, tune_nxt;
    logic [1:0] band_nxt;
    logic [3:0] fine_r;
    logic half_r, half_nxt;
    logic write_r, write_nxt;
    logic read_r, read_nxt;
    logic [15:0] disp_r, disp_nxt;
    logic [3:0] band_o_r, band_o_nxt;
    logic defeat_n_r, defeat_n_nxt;
    logic manual;
    logic cmd_rise;

    assign key_hold = (tune_up_in ^ tune_down_in) && mains_r == tuning_pkg::M_ON;
    assign cmd_rise = mains_cmd_in && !cmd_d_r;

    always_comb
    begin
        mains_nxt = mains_r;
        timer_nxt = timer_r;
        hold_cnt_nxt = 32'h0;
        on_nxt = on_r;
        pos_nxt = pos_r;
        store_en_nxt = store_en_r;
        addr_wait_nxt = addr_wait_r;
        tune_nxt = tune_r;
        band_nxt = band_r;
        half_nxt = half_r;
        write_nxt = 1'b0;
        read_nxt = 1'b0;
        manual = 1'b0;
        unique case (mains_r)
            tuning_pkg::M_POR:
            begin
                if (timer_r + 32'h1 >= POR_CYC) // R10
                begin
                    timer_nxt = 32'h0;
                    if (!poweron_opt_s) // R7
                    begin
                        mains_nxt = tuning_pkg::M_DELAY;
                        on_nxt = 1'b1;
                        pos_nxt = tuning_pkg::POS_FIRST;
                    end
                    else
                    begin
                        mains_nxt = tuning_pkg::M_OFF;
                    end
                end
                else
                begin
                    timer_nxt = timer_r + 32'h1;
                end
            end
            tuning_pkg::M_OFF:
            begin
                // short presses just drop the count
                if (mains_cmd_in && hold_cnt_r + 32'h1 >= MAINS_HOLD_CYC) // R8
                begin
                    mains_nxt = tuning_pkg::M_DELAY;
                    on_nxt = 1'b1;
                    timer_nxt = 32'h0;
                end
                else if (mains_cmd_in)
                begin
                    hold_cnt_nxt = hold_cnt_r + 32'h1;
                end
            end
            tuning_pkg::M_DELAY:
            begin
                if (cmd_rise) // R11
                begin
                    mains_nxt = tuning_pkg::M_OFF;
                    on_nxt = 1'b0;
                end
                else if (timer_r + 32'h1 >= READ_DELAY_CYC) // R9
                begin
                    mains_nxt = tuning_pkg::M_ON;
                    timer_nxt = 32'h0;
                    read_nxt = 1'b1; // R12
                end
                else
                begin
                    timer_nxt = timer_r + 32'h1;
                end
            end
            tuning_pkg::M_ON:
            begin
                if (cmd_rise) // R11
                begin
                    mains_nxt = tuning_pkg::M_OFF;
                    on_nxt = 1'b0;
                    addr_wait_nxt = 1'b0;
                end
            end
        endcase

        if (rd_valid_in)
        begin
            tune_nxt = rd_tune_in;
            band_nxt = rd_band_in;
        end

        if (mains_r == tuning_pkg::M_ON && mains_nxt == tuning_pkg::M_ON)
        begin
            manual = key_hold || rc_tune_up_in || rc_tune_down_in;
            if (addr_wait_r)
            begin
                if (rc_sel_valid_in)
                begin
                    pos_nxt = rc_sel_in; // R6
                    write_nxt = 1'b1;
                    addr_wait_nxt = 1'b0;
                    store_en_nxt = 1'b0; // R2
                end
            end
            else if (rc_sel_valid_in) // R14
            begin
                pos_nxt = rc_sel_in;
                read_nxt = 1'b1;
                store_en_nxt = 1'b1; // R3
            end
            else if (mem_up_in ^ mem_down_in)
            begin
                pos_nxt = next_pos(pos_r, mem_up_in, !station16_opt_s); // R15
                read_nxt = 1'b1;
                store_en_nxt = 1'b1; // R3
            end
            else if (store_cmd_in && store_en_r)
            begin
                write_nxt = 1'b1; // R4
                store_en_nxt = 1'b0; // R2
            end
            else if (addr_store_cmd_in && store_en_r)
            begin
                addr_wait_nxt = 1'b1; // R5
            end
            else if (band_step_in)
            begin
                band_nxt = next_band(band_r, band_pin_s | band_o_r); // R17
                store_en_nxt = 1'b1;
            end
            // a pulse left over after release would step the wrong way
            else if (accel_step && key_hold)
            begin
                tune_nxt = sat_step(tune_r, tune_up_in); // R21
                store_en_nxt = 1'b1; // R3
            end
            else if (rc_tune_up_in ^ rc_tune_down_in)
            begin
                half_nxt = !half_r; // R18
                if (half_r)
                begin
                    tune_nxt = sat_step(tune_r, rc_tune_up_in);
                    store_en_nxt = 1'b1; // R3
                end
            end
            else if (afc_up_in ^ afc_down_in)
            begin
                // frequency-lock corrections leave the store enable alone
                tune_nxt = sat_step(tune_r, afc_up_in); // R3
            end
        end

        aft_cnt_nxt = manual ? 32'(AFT_HOLD_CYC) : (aft_cnt_r != 32'h0 ? aft_cnt_r - 32'h1 : 32'h0);
        defeat_n_nxt = !(manual || aft_cnt_nxt != 32'h0); // R19
        // position indicator outputs are write-only: never read back
        disp_nxt = (addr_wait_nxt || !on_nxt) ? 16'h0 : 16'h1 << pos_nxt; // R13
        band_o_nxt = on_nxt ? 4'h1 << band_nxt : 4'h0; // R16
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            mains_r <= tuning_pkg::M_POR;
            timer_r <= 32'h0;
            hold_cnt_r <= 32'h0;
            aft_cnt_r <= 32'h0;
            cmd_d_r <= 1'b0;
            on_r <= 1'b0;
            pos_r <= tuning_pkg::POS_FIRST;
            store_en_r <= 1'b1;
            addr_wait_r <= 1'b0;
            tune_r <= tuning_pkg::TUNE_MIN;
            band_r <= tuning_pkg::BAND_VHF1;
            fine_r <= 4'h0;
            half_r <= 1'b0;
            write_r <= 1'b0;
            read_r <= 1'b0;
            disp_r <= 16'h0;
            band_o_r <= 4'h0;
            defeat_n_r <= 1'b1;
        end
        else
        begin
            mains_r <= mains_nxt;
            timer_r <= timer_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            aft_cnt_r <= aft_cnt_nxt;
            cmd_d_r <= mains_cmd_in;
            on_r <= on_nxt;
            pos_r <= pos_nxt;
            store_en_r <= store_en_nxt;
            addr_wait_r <= addr_wait_nxt;
            tune_r <= tune_nxt;
            band_r <= band_nxt;
            fine_r <= fine_in;
            half_r <= half_nxt;
            write_r <= write_nxt;
            read_r <= read_nxt;
            disp_r <= disp_nxt;
            band_o_r <= band_o_nxt;
            defeat_n_r <= defeat_n_nxt;
        end
    end

    assign mains_on_out = on_r;
    assign mem_pos_out = disp_r;
    assign band_out = band_o_r;
    // unselected band pins released so a grounded one can be seen
    assign band_oe_n_out = ~band_o_r; // R16
    assign tune_out = tune_r;
    assign fine_out = fine_r;
    assign band_code_out = band_r;
    assign mem_addr_out = pos_r;
    assign mem_write_out = write_r;
    assign mem_read_out = read_r;
    assign lin_aft_defeat_n_out = defeat_n_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    a_store_once: assert property (mem_write_out |-> !store_en_r) // R2
        else $error("store still enabled after a write");
    a_store_addr: assert property (mains_r == tuning_pkg::M_ON && !cmd_rise && !addr_wait_r && !rc_sel_valid_in
        && !(mem_up_in ^ mem_down_in) && store_cmd_in && store_en_r |=> mem_write_out && mem_addr_out == $past(pos_r)) // R4
        else $error("plain store missed or wrong position");
    a_blank_wait: assert property (addr_wait_r |-> mem_pos_out == 16'h0) // R5
        else $error("display not blanked while waiting for position");
    a_addr_write: assert property (mains_r == tuning_pkg::M_ON && !cmd_rise && addr_wait_r && rc_sel_valid_in
        |=> mem_write_out && mem_addr_out == $past(rc_sel_in) && mem_pos_out != 16'h0) // R6
        else $error("addressed store did not write and restore display");
    a_short_mains: assert property ($past(mains_r) == tuning_pkg::M_OFF && mains_r == tuning_pkg::M_DELAY
        |-> $past(hold_cnt_r) + 32'h1 >= MAINS_HOLD_CYC) // R8
        else $error("mains switched on by a short command");
    a_read_delay: assert property ($rose(mains_on_out) |-> !mem_read_out [*8]) // R9
        else $error("memory read without mains-on delay");
    a_tune_sat: assert property ((tune_r == tuning_pkg::TUNE_MAX || tune_r == tuning_pkg::TUNE_MIN)
        && !rd_valid_in |=> tune_r != ~$past(tune_r)) // R21
        else $error("tuning counter wrapped");
    a_skip_upper: assert property (!station16_opt_s && pos_r[3] == 1'b0 && !rc_sel_valid_in
        && !addr_wait_r |=> pos_r[3] == 1'b0) // R15
        else $error("stepping entered positions 9 to 16");
    a_defeat_low: assert property (manual |=> !lin_aft_defeat_n_out ##1 !lin_aft_defeat_n_out) // R19
        else $error("aft defeat not held low");
    a_pos_kept: assert property ($fell(mains_on_out) |=> $stable(mem_addr_out)) // R12
        else $error("position lost at mains off");

endmodule : tuning_store_mains_control
`default_nettype wire

// ===== bench/tuner_partner.sv
// memory and band pin model at the far side of the tuning block
`timescale 1ns/10ps
`default_nettype none
module tuner_partner #(
    parameter logic [3:0] GND_MASK = 4'h4
) (
    input wire logic clk_in,
    input wire logic mem_write_in,
    input wire logic mem_read_in,
    input wire logic [3:0] addr_in,
    input wire logic [12:0] tune_in,
    input wire logic [1:0] band_in,
    output var logic rd_valid_out = 1'b0,
    output var logic [12:0] rd_tune_out = 13'h0000,
    output var logic [1:0] rd_band_out = 2'h0,
    output logic [3:0] band_pin_out
);
    // ****
    // memory cells and pin levels
    // ****
    logic [14:0] mem_r [16] = '{default: 15'h0000};
    // shorted pins read low, the rest float up
    assign band_pin_out = ~GND_MASK;
    always_ff @(posedge clk_in)
    begin
        rd_valid_out <= mem_read_in;
        if (mem_write_in) mem_r[addr_in] <= {band_in, tune_in};
        // stale data must not look valid
        if (mem_read_in) {rd_band_out, rd_tune_out} <= mem_r[addr_in];
        else {rd_band_out, rd_tune_out} <= ~{rd_band_out, rd_tune_out};
    end
endmodule : tuner_partner
`default_nettype wire

// ===== bench/tuning_store_mains_control_bench.sv
// self-checking bench for the tuning, store and mains control block
`timescale 1ns/10ps
`default_nettype none
module tuning_store_mains_control_bench;
    // ****
    // signals, model state and tasks
    // ****
    logic clk_in = 1'b0, srst_in = 1'b1, poweron_opt_in = 1'b0, station16_opt_in = 1'b1;
    logic tune_up_in = 1'b0, tune_down_in = 1'b0, mains_cmd_in = 1'b0, rd_valid_in, mains_on_out;
    logic mem_write_out, mem_read_out, lin_aft_defeat_n_out;
    logic [15:0] mem_pos_out;
    logic [3:0] band_out, band_oe_n_out, fine_out, mem_addr_out, band_pin_in;
    logic [3:0] fine_in = 4'h0, rc_sel_in = 4'h0;
    logic [12:0] tune_out, rd_tune_in;
    logic [1:0] band_code_out, rd_band_in;
    logic [9:0] pc = 10'h000;
    logic [3:0] seq [3] = '{4'h2, 4'h8, 4'h1};
    int failures = 0, num_checks = 0, n, p;
    tuning_store_mains_control #(.POR_CYC(20), .MAINS_HOLD_CYC(30), .READ_DELAY_CYC(50), .AFT_HOLD_CYC(40),
        .ACCEL_STAGE_CYC(200), .VHF_PERIOD_CYC(32), .UHF_PERIOD_CYC(128)) tuning_store_mains_control_inst (
        .clk_in, .srst_in, .poweron_opt_in, .station16_opt_in, .band_pin_in, .tune_up_in, .tune_down_in,
        .rc_tune_up_in(pc[5]), .rc_tune_down_in(pc[6]), .afc_up_in(pc[7]), .afc_down_in(pc[8]),
        .mem_up_in(pc[2]), .mem_down_in(pc[3]), .rc_sel_valid_in(pc[9]), .rc_sel_in, .store_cmd_in(pc[0]),
        .addr_store_cmd_in(pc[1]), .band_step_in(pc[4]), .mains_cmd_in, .fine_in, .rd_valid_in, .rd_tune_in,
        .rd_band_in, .mains_on_out, .mem_pos_out, .band_out, .band_oe_n_out, .tune_out, .fine_out,
        .band_code_out, .mem_addr_out, .mem_write_out, .mem_read_out, .lin_aft_defeat_n_out);
    tuner_partner tuner_partner_inst (.clk_in, .mem_write_in(mem_write_out), .mem_read_in(mem_read_out),
        .addr_in(mem_addr_out), .tune_in(tune_out), .band_in(band_code_out), .rd_valid_out(rd_valid_in),
        .rd_tune_out(rd_tune_in), .rd_band_out(rd_band_in), .band_pin_out(band_pin_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic pulse(input int i);
        @(posedge clk_in) pc[i] <= 1'b1;
        @(posedge clk_in) pc[i] <= 1'b0;
        #1;
    endtask : pulse
    task automatic wait_hi(input bit rd);
        n = 0;
        while ((rd ? mem_read_out : mains_on_out) !== 1'b1 && n < 300)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
    endtask : wait_hi
    task automatic stop_test;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    initial forever #2 clk_in = ~clk_in;
    // a hang counts as a failure
    initial
    begin
        #100000;
        failures++;
        stop_test();
    end
    // ****
    // scenarios
    // ****
    initial
    begin
        void'($urandom(97088));
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        wait_hi(0);
        chk(mains_on_out, 1'b1);
        chk(mem_addr_out, 4'h0);
        wait_hi(1);
        chk(n, 50);
        for (int i = 0; i < 3; i++)
        begin
            pulse(4);
            chk({band_out, band_oe_n_out}, {seq[i], ~seq[i]});
        end
        pulse(5);
        pulse(5);
        chk(tune_out, 13'h0001);
        pulse(6);
        pulse(6);
        chk(tune_out, 13'h0000);
        chk(lin_aft_defeat_n_out, 1'b0);
        @(posedge clk_in) tune_down_in <= 1'b1;
        repeat (200) @(posedge clk_in);
        tune_down_in <= 1'b0;
        #1;
        chk({tune_out, band_code_out, band_out}, {13'h0000, 2'h0, 4'h1});
        repeat (39) @(posedge clk_in);
        #1;
        chk(lin_aft_defeat_n_out, 1'b0);
        @(posedge clk_in);
        #1;
        chk(lin_aft_defeat_n_out, 1'b1);
        @(posedge clk_in) tune_up_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        #1;
        p = tune_out;
        repeat (64) @(posedge clk_in);
        #1;
        chk(tune_out - p, 32'h2);
        repeat (800) @(posedge clk_in);
        #1;
        p = tune_out;
        repeat (64) @(posedge clk_in);
        tune_up_in <= 1'b0;
        #1;
        chk(tune_out - p, 32'h10);
        p = $urandom % 16;
        fine_in <= 4'(p);
        pulse(0);
        chk({mem_write_out, fine_out}, {1'b1, 4'(p)});
        pulse(0);
        chk(mem_write_out, 1'b0);
        pulse(7);
        pulse(0);
        chk(mem_write_out, 1'b0);
        pulse(2);
        chk({mem_read_out, mem_addr_out}, 5'h11);
        pulse(0);
        chk({mem_write_out, mem_addr_out}, 5'h11);
        pulse(2);
        p = $urandom % 8;
        rc_sel_in <= 4'(p);
        pulse(1);
        chk(mem_pos_out, 16'h0000);
        pulse(9);
        chk({mem_write_out, mem_addr_out, mem_pos_out}, {1'b1, 4'(p), 16'h0001 << p});
        station16_opt_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        for (int k = 0; k < 8 - p; k++) pulse(2);
        chk({mem_addr_out, mem_pos_out}, {4'h0, 16'h0001});
        pulse(3);
        chk({mem_addr_out, mem_pos_out}, {4'h7, 16'h0080});
        @(posedge clk_in) mains_cmd_in <= 1'b1;
        @(posedge clk_in);
        @(posedge clk_in) mains_cmd_in <= 1'b0;
        #1;
        chk({mains_on_out, mem_pos_out}, 17'h00000);
        @(posedge clk_in) mains_cmd_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        mains_cmd_in <= 1'b0;
        repeat (40) @(posedge clk_in);
        chk(mains_on_out, 1'b0);
        mains_cmd_in <= 1'b1;
        wait_hi(0);
        chk(mains_on_out, 1'b1);
        wait_hi(1);
        chk({n[7:0], mem_addr_out}, {8'd50, 4'h7});
        @(posedge clk_in) mains_cmd_in <= 1'b0;
        stop_test();
    end
endmodule : tuning_store_mains_control_bench
`default_nettype wire
